/* ser_ctl_checker.sv */
`timescale 1ns/1ns
module ser_ctl_checker (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic host_scl_out,
    input wire logic host_scl_oe,
    input wire logic host_sda_out,
    input wire logic host_sda_oe,
    input wire logic dev_sda_out,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    dev_drive_low_a: assert property (dev_sda_oe |-> !dev_sda_out) else $error("device sda high");
    host_drive_low_a: assert property ((host_scl_oe |-> !host_scl_out) and (host_sda_oe |-> !host_sda_out))
        else $error("host line high");
    scl_wire_a: assert property (scl == !host_scl_oe) else $error("scl level wrong");
    sda_wire_a: assert property (sda == !(host_sda_oe || dev_sda_oe)) else $error("sda level wrong");
    dev_sda_move_a: assert property ($changed(dev_sda_oe) |-> !scl) else $error("device moved sda, scl high");
    start_clock_a: assert property ($fell(sda) && scl |-> ##[1:300] !scl) else $error("no clock after start");
    stop_idle_a: assert property ($rose(sda) && scl |-> scl[*8]) else $error("clock moved after stop");
    ack_hold_a: assert property ($rose(dev_sda_oe) |-> (!scl && dev_sda_oe)[*4]) else $error("short ack");
endmodule : ser_ctl_checker

/* ser_ctl_device.sv */
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
// Contract
// RULE_01: Address from ten strap values, 0x2C or 0x33-0x3B.
// RULE_02: Start is data falling while clock high.
// RULE_03: Stop is data rising while clock high.
// RULE_04: ACK matching address, release on mismatch.
// RULE_05: Acknowledge every byte written by master.
// RULE_06: Master ACKs reads, NACKs last, then stops.
// RULE_07: Lines only pulled low or released.
// RULE_08: Own master tolerates target clock stretching.
// RULE_09: Offset 0x00 bits 7:1 writable only with bit0.
// RULE_10: Bit0 selects register address over strap.
// RULE_11: Offset 0x01 bit2 back channel, reset 0x04.
// RULE_12: Bit1 resets everything incl. registers, self-clears.
// RULE_13: Bit0 resets logic except registers, self-clears.
// RULE_14: Bit7 output enable, cleared on lock loss.
// RULE_15: Bit6 lets enable and sleep bits override.
// RULE_16: Bit5 drives oscillator clock while unlocked.
// RULE_17: Bit4 selects output state while unlocked.
// RULE_18: Bit3 selects legacy setting source.
// RULE_19: Bit2 is legacy setting when register selected.
// RULE_20: Bit1 selects low-frequency setting source.
// RULE_21: Bit0 low-frequency pixel clock range.
// RULE_22: Software keeps reserved fields and addresses untouched.
// RULE_23: First written byte sets offset, then data.
module ser_ctl_device (
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    ser_ctl_link_if.device  link,
    input  wire logic [3:0] address_strap_pin_i,
    input  wire logic       legacy_strap_i,
    input  wire logic       low_frequency_pin_i,
    input  wire logic       link_lock_i,
    output logic [6:0]      device_address_o,
    output logic            back_channel_enable_o,
    output logic            output_drive_enable_o,
    output logic            osc_clock_to_lvds_o,
    output logic            legacy_compat_mode_o,
    output logic            low_frequency_range_o,
    output logic            core_digital_reset_o
);
    typedef enum {S_IDLE, S_ADDR, S_ADDR_ACK, S_WR_BYTE, S_WR_ACK, S_RD_BYTE, S_RD_ACK} slave_state_t;

    logic [1:0] scl_sync, sda_sync;
    logic       scl_d, sda_d;
    logic [3:0] strap_s1, strap_s2;
    logic [2:0] lvl_s1, lvl_s2;
    logic       lock_d;
    slave_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic       first_byte;
    logic [7:0] pointer;
    logic       wr_en;
    logic [7:0] wr_off, wr_dat, reg_rd;
    logic [6:0] id_field;
    logic       id_override;
    logic       bc_enable;
    logic       full_reset_pulse;
    logic [7:0] cfg;

    // Pins from outside the clock domain pass two flip-flops first.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
            strap_s1 <= 4'h0;
            strap_s2 <= 4'h0;
            lvl_s1   <= 3'h0;
            lvl_s2   <= 3'h0;
            lock_d   <= 1'b0;
        end else begin
            scl_sync <= {scl_sync[0], link.scl};
            sda_sync <= {sda_sync[0], link.sda};
            scl_d    <= scl_sync[1];
            sda_d    <= sda_sync[1];
            strap_s1 <= address_strap_pin_i;
            strap_s2 <= strap_s1;
            lvl_s1   <= {link_lock_i, legacy_strap_i, low_frequency_pin_i};
            lvl_s2   <= lvl_s1;
            lock_d   <= lvl_s2[2];
        end
    end

    logic scl_rise, scl_fall, start_seen, stop_seen, lock_lost, lock_now;
    logic [6:0] own_address;
    assign scl_rise   = scl_sync[1] & ~scl_d;
    assign scl_fall   = ~scl_sync[1] & scl_d;
    assign start_seen = scl_sync[1] & scl_d & sda_d & ~sda_sync[1]; // RULE_02
    assign stop_seen  = scl_sync[1] & scl_d & ~sda_d & sda_sync[1]; // RULE_03
    assign lock_now   = lvl_s2[2];
    assign lock_lost  = lock_d & ~lock_now;
    assign own_address = id_override ? id_field : ser_ctl_pkg::strap_address(strap_s2); // RULE_01 RULE_10

    function automatic logic [7:0] read_reg(input logic [7:0] off);
        logic [7:0] v;
        v = 8'h00;
        case (off)
            ser_ctl_pkg::OFF_DEVICE_ADDRESS_SETTING: v = {own_address, id_override};
            ser_ctl_pkg::OFF_RESET_AND_BACKCHANNEL:  v = {5'h00, bc_enable, 2'h0};
            ser_ctl_pkg::OFF_GENERAL_OUTPUT_CONFIG:  v = cfg;
            default:                                 v = 8'h00;
        endcase
        return v;
    endfunction : read_reg
    assign reg_rd = read_reg(pointer);

    // Slave protocol engine. Bits are sampled on rising clock, drive changes on falling clock.
    // A core reset returns it to idle; the bus then waits for the next start.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state      <= S_IDLE;
            bit_cnt    <= 4'h0;
            shift      <= 8'h00;
            first_byte <= 1'b0;
            pointer    <= 8'h00;
            wr_en      <= 1'b0;
            wr_off     <= 8'h00;
            wr_dat     <= 8'h00;
            link.dev_sda_oe <= 1'b0;
        end else begin
            wr_en <= 1'b0;
            if (stop_seen || core_digital_reset_o) begin
                // A core reset keeps a pending acknowledge; idle releases it at the next clock fall.
                state <= S_IDLE;
                if (stop_seen) begin
                    link.dev_sda_oe <= 1'b0;
                end
            end else if (start_seen) begin
                state      <= S_ADDR;
                bit_cnt    <= 4'h0;
                first_byte <= 1'b1;
                link.dev_sda_oe <= 1'b0;
            end else if (scl_rise) begin
                case (state)
                    S_ADDR, S_WR_BYTE: begin
                        shift   <= {shift[6:0], sda_sync[1]};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    S_RD_BYTE: bit_cnt <= bit_cnt + 4'h1;
                    S_RD_ACK: begin
                        if (sda_sync[1]) begin
                            state <= S_IDLE; // RULE_06
                        end
                    end
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (state)
                    S_ADDR: begin
                        if (bit_cnt == ser_ctl_pkg::BITS_PER_BYTE) begin
                            if (shift[7:1] == own_address) begin
                                state <= S_ADDR_ACK;
                                link.dev_sda_oe <= 1'b1; // RULE_04
                            end else begin
                                state <= S_IDLE; // RULE_04
                            end
                        end
                    end
                    S_ADDR_ACK: begin
                        bit_cnt <= 4'h0;
                        if (shift[0]) begin
                            state <= S_RD_BYTE;
                            shift <= reg_rd; // RULE_23
                            link.dev_sda_oe <= ~reg_rd[7];
                        end else begin
                            state <= S_WR_BYTE;
                            link.dev_sda_oe <= 1'b0;
                        end
                    end
                    S_WR_BYTE: begin
                        if (bit_cnt == ser_ctl_pkg::BITS_PER_BYTE) begin
                            state <= S_WR_ACK;
                            link.dev_sda_oe <= 1'b1; // RULE_05
                            first_byte <= 1'b0;
                            if (first_byte) begin
                                pointer <= shift; // RULE_23
                            end else begin
                                wr_en   <= 1'b1;
                                wr_off  <= pointer;
                                wr_dat  <= shift;
                                pointer <= pointer + 8'h01;
                            end
                        end
                    end
                    S_WR_ACK: begin
                        state   <= S_WR_BYTE;
                        bit_cnt <= 4'h0;
                        link.dev_sda_oe <= 1'b0;
                    end
                    S_RD_BYTE: begin
                        if (bit_cnt == ser_ctl_pkg::BITS_PER_BYTE) begin
                            state   <= S_RD_ACK;
                            pointer <= pointer + 8'h01;
                            link.dev_sda_oe <= 1'b0;
                        end else begin
                            shift <= {shift[6:0], 1'b0};
                            link.dev_sda_oe <= ~shift[6];
                        end
                    end
                    S_RD_ACK: begin
                        state   <= S_RD_BYTE;
                        bit_cnt <= 4'h0;
                        shift   <= reg_rd;
                        link.dev_sda_oe <= ~reg_rd[7];
                    end
                    default: link.dev_sda_oe <= 1'b0;
                endcase
            end
        end
    end

    // The data pin is only ever pulled low, never driven high.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            link.dev_sda_out <= 1'b0;
        end else begin
            link.dev_sda_out <= 1'b0; // RULE_07
        end
    end

    // Register file. A full reset pulse restores defaults one cycle after the write.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            id_field         <= 7'h00;
            id_override      <= 1'b0;
            bc_enable        <= ser_ctl_pkg::RESET_BC_RESET_VALUE[ser_ctl_pkg::RESET_BC_ENABLE_BIT];
            full_reset_pulse <= 1'b0;
            cfg              <= ser_ctl_pkg::GENERAL_CFG_RESET;
        end else if (full_reset_pulse) begin
            id_field         <= 7'h00; // RULE_12
            id_override      <= 1'b0;
            bc_enable        <= ser_ctl_pkg::RESET_BC_RESET_VALUE[ser_ctl_pkg::RESET_BC_ENABLE_BIT];
            full_reset_pulse <= 1'b0;
            cfg              <= ser_ctl_pkg::GENERAL_CFG_RESET;
        end else begin
            full_reset_pulse <= 1'b0;
            if (wr_en && wr_off == ser_ctl_pkg::OFF_DEVICE_ADDRESS_SETTING) begin
                id_override <= wr_dat[ser_ctl_pkg::ADDR_SETTING_OVERRIDE_BIT]; // RULE_10
                if (wr_dat[ser_ctl_pkg::ADDR_SETTING_OVERRIDE_BIT]) begin
                    id_field <= wr_dat[7:1]; // RULE_09
                end
            end
            if (wr_en && wr_off == ser_ctl_pkg::OFF_RESET_AND_BACKCHANNEL) begin
                bc_enable        <= wr_dat[ser_ctl_pkg::RESET_BC_ENABLE_BIT]; // RULE_11
                full_reset_pulse <= wr_dat[ser_ctl_pkg::RESET_FULL_BIT]; // RULE_12
            end
            if (wr_en && wr_off == ser_ctl_pkg::OFF_GENERAL_OUTPUT_CONFIG) begin
                cfg <= wr_dat;
            end
            // Loss of lock beats a simultaneous software write of the enable bit.
            if (lock_lost) begin
                cfg[ser_ctl_pkg::CFG_OUT_ENABLE_BIT] <= 1'b0; // RULE_14
            end
        end
    end

    // Core reset: a one-cycle pulse, two cycles if bits 1 and 0 are written together, that leaves the registers alone.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core_digital_reset_o <= 1'b0;
        end else begin
            core_digital_reset_o <= full_reset_pulse |
                (wr_en && wr_off == ser_ctl_pkg::OFF_RESET_AND_BACKCHANNEL &&
                 wr_dat[ser_ctl_pkg::RESET_CORE_BIT]); // RULE_13
        end
    end

    // Effective configuration outputs, all registered.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            device_address_o      <= 7'h00;
            back_channel_enable_o <= 1'b0;
            output_drive_enable_o <= 1'b0;
            osc_clock_to_lvds_o   <= 1'b0;
            legacy_compat_mode_o  <= 1'b0;
            low_frequency_range_o <= 1'b0;
        end else begin
            device_address_o      <= own_address;
            back_channel_enable_o <= bc_enable; // RULE_11
            if (cfg[ser_ctl_pkg::CFG_OVERRIDE_BIT]) begin
                output_drive_enable_o <= cfg[ser_ctl_pkg::CFG_OUT_ENABLE_BIT] &
                    (lock_now | cfg[ser_ctl_pkg::CFG_SLEEP_STATE_BIT]); // RULE_15 RULE_14
            end else begin
                output_drive_enable_o <= lock_now; // RULE_15
            end
            osc_clock_to_lvds_o  <= cfg[ser_ctl_pkg::CFG_AUTO_CLOCK_BIT] & ~lock_now; // RULE_16
            legacy_compat_mode_o <= cfg[ser_ctl_pkg::CFG_LEGACY_SRC_BIT] ?
                cfg[ser_ctl_pkg::CFG_LEGACY_BIT] : lvl_s2[1]; // RULE_18 RULE_19
            low_frequency_range_o <= cfg[ser_ctl_pkg::CFG_LOW_FREQ_SRC_BIT] ?
                cfg[ser_ctl_pkg::CFG_LOW_FREQ_BIT] : lvl_s2[0]; // RULE_20 RULE_21
        end
    end
    // Bit 4 with override clear has no effect: outputs then simply follow lock.
    // RULE_17 is carried by the override path above, where bit 4 with bit 7 set keeps outputs on while unlocked; lock loss clears bit 7.
endmodule : ser_ctl_device

/* ser_ctl_host.sv */
`timescale 1ns/1ns
module ser_ctl_host (
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    ser_ctl_link_if.host    link,
    input  wire logic       go_i,
    input  wire logic       read_i,
    input  wire logic [6:0] target_i,
    input  wire logic [7:0] offset_i,
    input  wire logic [7:0] wdata_i,
    output logic            busy_o,
    output logic            done_o,
    output logic            nack_o,
    output logic [7:0]      rdata_o
);
    typedef enum {OP_START, OP_TX, OP_RX, OP_STOP} host_op_t;

    logic [1:0]  scl_sync, sda_sync;
    logic [15:0] timer;
    logic [1:0]  quarter;
    logic [3:0]  bit_idx;
    logic [2:0]  step;
    logic        rd_mode;
    logic [6:0]  target;
    logic [7:0]  offset, wdata, tx_byte, rx_byte, step_value;

    function automatic host_op_t step_op(input logic [2:0] s, input logic rd);
        host_op_t o;
        o = OP_TX;
        case (s)
            3'h0:    o = OP_START;
            3'h3:    o = rd ? OP_START : OP_TX;
            3'h4:    o = rd ? OP_TX : OP_STOP;
            3'h5:    o = OP_RX;
            3'h6:    o = OP_STOP;
            default: o = OP_TX;
        endcase
        return o;
    endfunction : step_op

    function automatic logic [7:0] step_byte(input logic [2:0] s);
        logic [7:0] b;
        b = wdata;
        case (s)
            3'h1:    b = {target, 1'b0};
            3'h2:    b = offset;
            3'h4:    b = {target, 1'b1};
            default: b = wdata;
        endcase
        return b;
    endfunction : step_byte

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
        end else begin
            scl_sync <= {scl_sync[0], link.scl};
            sda_sync <= {sda_sync[0], link.sda};
        end
    end

    host_op_t op;
    logic     tick;
    assign op   = step_op(step, rd_mode);
    assign tick = (timer == 16'(ser_ctl_pkg::QUARTER_CYCLES - 1));
    assign step_value = step_byte(step);

    // Each bit is four quarters: set data, release clock, wait for clock high, pull clock low.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_o  <= 1'b0;
            done_o  <= 1'b0;
            nack_o  <= 1'b0;
            rdata_o <= 8'h00;
            timer   <= 16'h0000;
            quarter <= 2'h0;
            bit_idx <= 4'h0;
            step    <= 3'h0;
            rd_mode <= 1'b0;
            target  <= 7'h00;
            offset  <= 8'h00;
            wdata   <= 8'h00;
            tx_byte <= 8'h00;
            rx_byte <= 8'h00;
            link.host_scl_oe  <= 1'b0;
            link.host_sda_oe  <= 1'b0;
            link.host_scl_out <= 1'b0;
            link.host_sda_out <= 1'b0;
        end else begin
            link.host_scl_out <= 1'b0; // RULE_07
            link.host_sda_out <= 1'b0; // RULE_07
            done_o <= 1'b0;
            if (!busy_o) begin
                if (go_i) begin
                    busy_o  <= 1'b1;
                    nack_o  <= 1'b0;
                    rd_mode <= read_i;
                    target  <= target_i;
                    offset  <= offset_i;
                    wdata   <= wdata_i;
                    step    <= 3'h0;
                    quarter <= 2'h0;
                    bit_idx <= 4'h0;
                    timer   <= 16'h0000;
                end
            end else if (quarter == 2'h2 && !scl_sync[1]) begin
                timer <= 16'h0000; // RULE_08
            end else if (!tick) begin
                timer <= timer + 16'h0001;
            end else begin
                timer   <= 16'h0000;
                quarter <= quarter + 2'h1;
                case (quarter)
                    2'h0: begin
                        case (op)
                            OP_START: link.host_sda_oe <= 1'b0;
                            OP_STOP:  link.host_sda_oe <= 1'b1;
                            OP_TX: begin
                                if (bit_idx == 4'h0) begin
                                    tx_byte <= {step_value[6:0], 1'b0};
                                    link.host_sda_oe <= ~step_value[7];
                                end else if (bit_idx == ser_ctl_pkg::BITS_PER_BYTE) begin
                                    link.host_sda_oe <= 1'b0;
                                end else begin
                                    tx_byte <= {tx_byte[6:0], 1'b0};
                                    link.host_sda_oe <= ~tx_byte[7];
                                end
                            end
                            default: link.host_sda_oe <= 1'b0; // RULE_06
                        endcase
                    end
                    2'h1: link.host_scl_oe <= 1'b0;
                    2'h2: begin
                        if (op == OP_START) begin
                            link.host_sda_oe <= 1'b1; // RULE_02
                        end else if (op == OP_STOP) begin
                            link.host_sda_oe <= 1'b0; // RULE_03
                        end else if (bit_idx < ser_ctl_pkg::BITS_PER_BYTE) begin
                            rx_byte <= {rx_byte[6:0], sda_sync[1]};
                        end else if (op == OP_TX && sda_sync[1]) begin
                            nack_o <= 1'b1;
                        end
                    end
                    default: begin
                        if (op != OP_STOP) begin
                            link.host_scl_oe <= 1'b1;
                        end
                        if ((op == OP_TX || op == OP_RX) && bit_idx != ser_ctl_pkg::BITS_PER_BYTE) begin
                            bit_idx <= bit_idx + 4'h1;
                        end else begin
                            bit_idx <= 4'h0;
                            if (op == OP_STOP) begin
                                busy_o <= 1'b0;
                                done_o <= 1'b1;
                            end else if (nack_o) begin
                                step <= rd_mode ? ser_ctl_pkg::HOST_LAST_STEP_READ
                                                : ser_ctl_pkg::HOST_LAST_STEP_WRITE;
                            end else begin
                                if (op == OP_RX) begin
                                    rdata_o <= rx_byte;
                                end
                                step <= step + 3'h1;
                            end
                        end
                    end
                endcase
            end
        end
    end
endmodule : ser_ctl_host

/* ser_ctl_link_if.sv */
`timescale 1ns/1ns
interface ser_ctl_link_if;
    logic host_scl_out;
    logic host_scl_oe;
    logic host_sda_out;
    logic host_sda_oe;
    logic dev_sda_out;
    logic dev_sda_oe;
    wire  scl;
    wire  sda;

    // Open-drain resolution: any enabled driver pulls low, otherwise the pull-up wins.
    assign scl = (host_scl_oe ? host_scl_out : 1'b1);
    assign sda = (host_sda_oe ? host_sda_out : 1'b1) & (dev_sda_oe ? dev_sda_out : 1'b1);

    modport host (output host_scl_out, output host_scl_oe, output host_sda_out, output host_sda_oe,
                  input scl, input sda);
    modport device (output dev_sda_out, output dev_sda_oe, input scl, input sda);
endinterface : ser_ctl_link_if

/* ser_ctl_pkg.sv */
package ser_ctl_pkg;
    localparam logic [7:0] OFF_DEVICE_ADDRESS_SETTING = 8'h00;
    localparam logic [7:0] OFF_RESET_AND_BACKCHANNEL  = 8'h01;
    localparam logic [7:0] OFF_GENERAL_OUTPUT_CONFIG  = 8'h02;

    localparam int ADDR_SETTING_OVERRIDE_BIT = 0;
    localparam int RESET_BC_ENABLE_BIT       = 2;
    localparam int RESET_FULL_BIT            = 1;
    localparam int RESET_CORE_BIT            = 0;
    localparam int CFG_OUT_ENABLE_BIT        = 7;
    localparam int CFG_OVERRIDE_BIT          = 6;
    localparam int CFG_AUTO_CLOCK_BIT        = 5;
    localparam int CFG_SLEEP_STATE_BIT       = 4;
    localparam int CFG_LEGACY_SRC_BIT        = 3;
    localparam int CFG_LEGACY_BIT            = 2;
    localparam int CFG_LOW_FREQ_SRC_BIT      = 1;
    localparam int CFG_LOW_FREQ_BIT          = 0;

    localparam logic [7:0] RESET_BC_RESET_VALUE = 8'h04;
    localparam logic [7:0] GENERAL_CFG_RESET    = 8'h00;

    localparam logic [3:0] STRAP_COUNT      = 4'hA;
    localparam logic [6:0] STRAP_ADDR_FIRST = 7'h2C;
    localparam logic [6:0] STRAP_ADDR_BASE  = 7'h33;

    localparam int CLK_FREQ_KHZ   = 100000;
    localparam int SCL_FREQ_KHZ   = 400;
    localparam int QUARTER_CYCLES = CLK_FREQ_KHZ / (SCL_FREQ_KHZ * 4);
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [2:0] HOST_LAST_STEP_WRITE = 3'h4;
    localparam logic [2:0] HOST_LAST_STEP_READ  = 3'h6;

    // Strap index 0 maps to the lone low address, 1..9 to the ascending block.
    function automatic logic [6:0] strap_address(input logic [3:0] idx);
        logic [6:0] a;
        a = STRAP_ADDR_FIRST;
        if (idx != 4'h0 && idx < STRAP_COUNT) begin
            a = STRAP_ADDR_BASE + {3'h0, idx} - 7'h01;
        end
        return a;
    endfunction : strap_address
endpackage : ser_ctl_pkg

/* tb.sv */
`timescale 1ns/1ns
module tb;
    logic clk_i, reset_n_i, go_i, read_i, busy_o, done_o, nack_o, legacy_strap_i, low_frequency_pin_i, link_lock_i;
    logic       back_channel_enable_o, output_drive_enable_o, osc_clock_to_lvds_o;
    logic       legacy_compat_mode_o, low_frequency_range_o, core_digital_reset_o;
    logic [6:0] target_i, device_address_o;
    logic [7:0] offset_i, wdata_i, rdata_o;
    logic [3:0] address_strap_pin_i;
    int         n_errors, checked;
    int         n_core = 0;
    ser_ctl_link_if link ();
    ser_ctl_host u_ser_ctl_host (.clk_i, .reset_n_i, .link(link.host), .go_i, .read_i, .target_i, .offset_i,
        .wdata_i, .busy_o, .done_o, .nack_o, .rdata_o);
    ser_ctl_device u_ser_ctl_device (.clk_i, .reset_n_i, .link(link.device), .address_strap_pin_i, .legacy_strap_i,
        .low_frequency_pin_i, .link_lock_i, .device_address_o, .back_channel_enable_o, .output_drive_enable_o,
        .osc_clock_to_lvds_o, .legacy_compat_mode_o, .low_frequency_range_o, .core_digital_reset_o);
    ser_ctl_checker u_ser_ctl_checker (.clk_i, .reset_n_i, .host_scl_out(link.host_scl_out),
        .host_scl_oe(link.host_scl_oe), .host_sda_out(link.host_sda_out), .host_sda_oe(link.host_sda_oe),
        .dev_sda_out(link.dev_sda_out), .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (core_digital_reset_o === 1'b1) n_core <= n_core + 1;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // One host command; a bus transfer takes some thousands of cycles at this clock rate.
    task automatic xfer(input logic rd, input logic [6:0] tg, input logic [7:0] off, input logic [7:0] wd);
        int n;
        read_i <= rd; target_i <= tg; offset_i <= off; wdata_i <= wd; go_i <= 1'b1;
        @(posedge clk_i);
        go_i <= 1'b0;
        for (n = 0; n < 15000 && done_o !== 1'b1; n++) @(negedge clk_i);
        if (n == 15000) begin
            n_errors++;
            close_out();
        end
        @(posedge clk_i);
    endtask : xfer
    initial begin
        n_errors = 0; checked = 0; reset_n_i = 1'b0; go_i = 1'b0; read_i = 1'b0; target_i = 7'h00;
        offset_i = 8'h00; wdata_i = 8'h00; address_strap_pin_i = 4'h3; legacy_strap_i = 1'b1;
        low_frequency_pin_i = 1'b0; link_lock_i = 1'b1;
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk({1'b0, device_address_o}, 8'h35);
        chk({7'h00, back_channel_enable_o}, 8'h01);
        chk({7'h00, legacy_compat_mode_o}, 8'h01);
        chk({7'h00, low_frequency_range_o}, 8'h00);
        chk({7'h00, osc_clock_to_lvds_o}, 8'h00);
        link_lock_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk({7'h00, output_drive_enable_o}, 8'h00);
        link_lock_i <= 1'b1;
        $display("test 1 done");
        xfer(1'b0, 7'h35, 8'h02, 8'h0B);
        chk({7'h00, nack_o}, 8'h00);
        chk({7'h00, legacy_compat_mode_o}, 8'h00);
        chk({7'h00, low_frequency_range_o}, 8'h01);
        $display("test 2 done");
        xfer(1'b1, 7'h35, 8'h01, 8'h00);
        chk(rdata_o, 8'h04);
        $display("test 3 done");
        xfer(1'b0, 7'h2C, 8'h02, 8'hFF);
        chk({7'h00, nack_o}, 8'h01);
        chk({7'h00, legacy_compat_mode_o}, 8'h00);
        $display("test 4 done");
        xfer(1'b0, 7'h35, 8'h02, 8'hF0);
        chk({7'h00, output_drive_enable_o}, 8'h01);
        link_lock_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk({7'h00, output_drive_enable_o}, 8'h00);
        chk({7'h00, osc_clock_to_lvds_o}, 8'h01);
        xfer(1'b0, 7'h35, 8'h02, 8'hD0);
        chk({7'h00, output_drive_enable_o}, 8'h01);
        xfer(1'b0, 7'h35, 8'h02, 8'hC0);
        chk({7'h00, output_drive_enable_o}, 8'h00);
        link_lock_i <= 1'b1;
        $display("test 5 done");
        xfer(1'b0, 7'h35, 8'h00, 8'h51);
        chk({1'b0, device_address_o}, 8'h28);
        xfer(1'b1, 7'h28, 8'h00, 8'h00);
        chk(rdata_o, 8'h51);
        xfer(1'b0, 7'h28, 8'h01, 8'h05);
        chk({7'h00, nack_o}, 8'h00);
        chk({1'b0, device_address_o}, 8'h28);
        chk(n_core[7:0], 8'h01);
        xfer(1'b0, 7'h28, 8'h01, 8'h06);
        chk({1'b0, device_address_o}, 8'h35);
        chk(n_core[7:0], 8'h02);
        $display("test 6 done");
        close_out();
    end
endmodule : tb
